/* File: core/analog_output_channel_control.sv */
`timescale 1ns/10ps
`include "analog_out_defines.svh"

// Behaviour
// - Configuration bit 0 set enables a channel whose bits 4:2 hold range code 0-5, and cleared disables it.
// - Configuration bit 1 is stored but changes nothing in the output.
// - Bits 4:2 pick 0-5V, 0-10V, +-5V, +-10V, 4-20mA or 0-20mA.
// - Bits 6:5 pick clear, hold or preset once the controller stops.
// - Bits 15:7 are stored and otherwise ignored.
// - The coupler writes a 16-bit code that is output while running.
// - Each channel keeps a 16-bit preset applied by the preset policy.
// - Each channel has a read-only 16-bit word showing the present fault.
// - Codes are limited to the span of the selected range.
// - An open current loop reports b0, b2, b4 or b6 by channel.
// - A shorted voltage output reports b1, b3, b5 or b7 by channel.
// - Loss of the 24V output supply reports b8.
module analog_output_channel_control (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pd_wr_en,
    input wire analog_out_pkg::word_kind_e pd_wr_kind,
    input wire analog_out_pkg::chan_t pd_wr_ch,
    input wire analog_out_pkg::word_t pd_wdata,
    input wire analog_out_pkg::word_kind_e pd_rd_kind,
    input wire analog_out_pkg::chan_t pd_rd_ch,
    input wire logic run_cmd,
    input wire logic [3:0] open_loop_pin,
    input wire logic [3:0] short_out_pin,
    input wire logic power_lost_pin,
    output analog_out_pkg::word_t pd_rdata,
    output analog_out_pkg::word_t dac_value [`NUM_CH],
    output logic [2:0] dac_range [`NUM_CH],
    output logic [3:0] dac_enable,
    output logic fault_any
);
    import analog_out_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic word_hit(logic en, word_kind_e kind,
                                      chan_t ch, word_kind_e want,
                                      int idx);
        return en && kind == want && ch == chan_t'(idx);
    endfunction

    function automatic word_t fault_code(word_t base, int idx);
        return base + word_t'(2 * idx);
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // four identical channel sets
    word_t cfg_reg [`NUM_CH];
    word_t code_reg [`NUM_CH];
    word_t preset_reg [`NUM_CH];
    word_t fault_reg [`NUM_CH];
    word_t out_reg [`NUM_CH];
    logic [2:0] range_reg [`NUM_CH];
    logic [3:0] enable_reg;
    logic fault_any_reg;
    word_t rdata_reg;
    run_state_e run_state_reg;
    run_state_e run_state_next;

    // Fault pin synchronisers
    logic [3:0] open_sync1_reg;
    logic [3:0] open_sync2_reg;
    logic [3:0] short_sync1_reg;
    logic [3:0] short_sync2_reg;
    logic power_sync1_reg;
    logic power_sync2_reg;

    // Per-channel combinational results
    word_t value_next [`NUM_CH];
    word_t fault_next [`NUM_CH];
    logic [3:0] ch_enabled;
    logic [3:0] range_ok;
    logic [3:0] is_current;
    logic [3:0] is_voltage;
    logic [3:0] wr_cfg;
    logic [3:0] wr_code;
    logic [3:0] wr_preset;
    logic [3:0] open_hit;
    logic [3:0] short_hit;

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    always_comb begin
        run_state_next = run_state_reg;
        unique case (run_state_reg)
            run_stopped: begin
                if (run_cmd) begin
                    run_state_next = run_active;
                end
            end
            run_active: begin
                if (!run_cmd) begin
                    run_state_next = run_stopped;
                end
            end
        endcase
    end

    wire running = (run_state_reg == run_active);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_state_reg <= run_stopped;
        end else begin
            run_state_reg <= run_state_next;
        end
    end

    // ------------------------------------------------------------
    // Fault input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            open_sync1_reg <= 4'h0;
            open_sync2_reg <= 4'h0;
        end else begin
            open_sync1_reg <= open_loop_pin;
            open_sync2_reg <= open_sync1_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            short_sync1_reg <= 4'h0;
            short_sync2_reg <= 4'h0;
        end else begin
            short_sync1_reg <= short_out_pin;
            short_sync2_reg <= short_sync1_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_sync1_reg <= 1'b0;
            power_sync2_reg <= 1'b0;
        end else begin
            power_sync1_reg <= power_lost_pin;
            power_sync2_reg <= power_sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
        // Writes to the fault word are dropped
        assign wr_cfg[i] = word_hit(pd_wr_en, pd_wr_kind, pd_wr_ch,
                                    kind_config, i);
        assign wr_code[i] = word_hit(pd_wr_en, pd_wr_kind, pd_wr_ch,
                                     kind_code, i);
        assign wr_preset[i] = word_hit(pd_wr_en, pd_wr_kind, pd_wr_ch,
                                       kind_preset, i);

        channel_scaler u_scaler (
            .cfg(cfg_reg[i]),
            .code(code_reg[i]),
            .preset(preset_reg[i]),
            .held(out_reg[i]),
            .running(running),
            .value_next(value_next[i]),
            .ch_enabled(ch_enabled[i]),
            .range_ok(range_ok[i]),
            .is_current(is_current[i]),
            .is_voltage(is_voltage[i])
        );

        // ------------------------------------------------------------
        // Fault words
        // ------------------------------------------------------------
        // open current loop
        assign open_hit[i] = ch_enabled[i] && is_current[i] &&
                             open_sync2_reg[i];
        assign short_hit[i] = ch_enabled[i] && is_voltage[i] &&
                              short_sync2_reg[i];
        assign fault_next[i] =
            power_sync2_reg ? `FAULT_POWER :
            open_hit[i] ? fault_code(`FAULT_OPEN_BASE, i) :
            short_hit[i] ? fault_code(`FAULT_SHORT_BASE, i) :
            `FAULT_NONE;

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cfg_reg[i] <= `CFG_RESET;
            end else if (wr_cfg[i]) begin
                cfg_reg[i] <= pd_wdata;
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                code_reg[i] <= `CODE_RESET;
            end else if (wr_code[i]) begin
                code_reg[i] <= pd_wdata;
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                preset_reg[i] <= `PRESET_RESET;
            end else if (wr_preset[i]) begin
                preset_reg[i] <= pd_wdata;
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                fault_reg[i] <= `FAULT_NONE;
            end else begin
                fault_reg[i] <= fault_next[i];
            end
        end

        // ------------------------------------------------------------
        // Output registers
        // ------------------------------------------------------------
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                out_reg[i] <= `OUT_RESET;
            end else begin
                out_reg[i] <= value_next[i];
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                range_reg[i] <= `RANGE_0_5V;
            end else begin
                range_reg[i] <= cfg_reg[i][`CFG_RANGE_MSB:`CFG_RANGE_LSB];
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                enable_reg[i] <= 1'b0;
            end else begin
                enable_reg[i] <= ch_enabled[i] && range_ok[i];
            end
        end

        assign dac_value[i] = out_reg[i];
        assign dac_range[i] = range_reg[i];
    end

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    word_t rdata_next;

    always_comb begin
        rdata_next = `FAULT_NONE;
        unique case (pd_rd_kind)
            kind_config: rdata_next = cfg_reg[pd_rd_ch];
            kind_code: rdata_next = code_reg[pd_rd_ch];
            kind_preset: rdata_next = preset_reg[pd_rd_ch];
            kind_fault: rdata_next = fault_reg[pd_rd_ch];
        endcase
    end

    wire fault_any_next = (fault_next[0] != `FAULT_NONE) ||
                          (fault_next[1] != `FAULT_NONE) ||
                          (fault_next[2] != `FAULT_NONE) ||
                          (fault_next[3] != `FAULT_NONE);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= `FAULT_NONE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_any_reg <= 1'b0;
        end else begin
            fault_any_reg <= fault_any_next;
        end
    end

    assign pd_rdata = rdata_reg;
    assign dac_enable = enable_reg;
    assign fault_any = fault_any_reg;

endmodule

/* File: core/channel_scaler.sv */
`timescale 1ns/10ps
`include "analog_out_defines.svh"

module channel_scaler (
    input wire analog_out_pkg::word_t cfg,
    input wire analog_out_pkg::word_t code,
    input wire analog_out_pkg::word_t preset,
    input wire analog_out_pkg::word_t held,
    input wire logic running,
    output analog_out_pkg::word_t value_next,
    output logic ch_enabled,
    output logic range_ok,
    output logic is_current,
    output logic is_voltage
);
    import analog_out_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic word_t clamp_word(word_t v, word_t lo, word_t hi);
        if ($signed(v) < $signed(lo)) begin
            return lo;
        end
        if ($signed(v) > $signed(hi)) begin
            return hi;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // Bit 1 and bits 15:7 are never looked at
    wire range_t range_sel = cfg[`CFG_RANGE_MSB:`CFG_RANGE_LSB];
    wire stop_t stop_sel = cfg[`CFG_STOP_MSB:`CFG_STOP_LSB];
    word_t lim_lo;
    word_t lim_hi;

    assign ch_enabled = cfg[`CFG_ENABLE_BIT];

    always_comb begin
        lim_lo = `LIM_ZERO;
        lim_hi = `LIM_ZERO;
        range_ok = 1'b1;
        unique case (range_sel)
            `RANGE_0_5V: begin
                lim_hi = `LIM_P5000;
            end
            `RANGE_0_10V: begin
                lim_hi = `LIM_P10000;
            end
            `RANGE_PM5V: begin
                lim_lo = `LIM_M5000;
                lim_hi = `LIM_P5000;
            end
            `RANGE_PM10V: begin
                lim_lo = `LIM_M10000;
                lim_hi = `LIM_P10000;
            end
            `RANGE_4_20MA: begin
                lim_lo = `LIM_P4000;
                lim_hi = `LIM_P20000;
            end
            `RANGE_0_20MA: begin
                lim_hi = `LIM_P20000;
            end
            default: begin
                range_ok = 1'b0;
            end
        endcase
    end

    assign is_current = range_ok && (range_sel == `RANGE_4_20MA ||
                                     range_sel == `RANGE_0_20MA);
    assign is_voltage = range_ok && !is_current;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // clamp to range span
    wire word_t code_scaled = clamp_word(code, lim_lo, lim_hi);
    wire word_t preset_scaled = clamp_word(preset, lim_lo, lim_hi);

    always_comb begin
        value_next = `OUT_RESET;
        if (ch_enabled && range_ok) begin
            if (running) begin
                value_next = code_scaled;
            end else begin
                unique case (stop_sel)
                    `STOP_CLEAR: value_next = `OUT_RESET;
                    `STOP_HOLD: value_next = held;
                    `STOP_PRESET: value_next = preset_scaled;
                    default: value_next = `OUT_RESET;
                endcase
            end
        end
    end

endmodule

/* File: dv/analog_output_channel_control_assertions.sv */
`timescale 1ns/10ps
`include "analog_out_defines.svh"

module output_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pd_wr_en,
    input wire analog_out_pkg::word_kind_e pd_wr_kind,
    input wire analog_out_pkg::chan_t pd_wr_ch,
    input wire analog_out_pkg::word_t pd_wdata,
    input wire analog_out_pkg::word_kind_e pd_rd_kind,
    input wire analog_out_pkg::chan_t pd_rd_ch,
    input wire logic run_cmd,
    input wire logic [3:0] open_loop_pin,
    input wire logic [3:0] short_out_pin,
    input wire logic power_lost_pin,
    input wire analog_out_pkg::word_t pd_rdata,
    input wire analog_out_pkg::word_t dac_value [`NUM_CH],
    input wire logic [2:0] dac_range [`NUM_CH],
    input wire logic [3:0] dac_enable,
    input wire logic fault_any
);
    import analog_out_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    function automatic logic in_span(logic [2:0] r, word_t v);
        logic signed [15:0] s;
        s = v;
        case (r)
            3'h0: in_span = s >= 16'sh0 && s <= 16'sh1388;
            3'h1: in_span = s >= 16'sh0 && s <= 16'sh2710;
            3'h2: in_span = s >= -16'sh1388 && s <= 16'sh1388;
            3'h3: in_span = s >= -16'sh2710 && s <= 16'sh2710;
            3'h4: in_span = s >= 16'sh0fa0 && s <= 16'sh4e20;
            3'h5: in_span = s >= 16'sh0 && s <= 16'sh4e20;
            default: in_span = v == 16'h0;
        endcase
    endfunction

    sequence cfg_wr(int c);
        pd_wr_en && pd_wr_kind == kind_config && pd_wr_ch == c
        ##1 !(pd_wr_en && pd_wr_kind == kind_config);
    endsequence

    for (genvar g = 0; g < `NUM_CH; g++) begin : per_ch
        a_off_zero: assert property (
            !dac_enable[g] |-> dac_value[g] == 16'h0)
            else $error("disabled channel drives nonzero");
        a_en_from_cfg: assert property (
            cfg_wr(g) |=> dac_enable[g] == ($past(pd_wdata[0], 2)
            && $past(pd_wdata[4:2], 2) <= 3'h5))
            else $error("enable does not follow config");
        a_range_copy: assert property (
            cfg_wr(g) |=> dac_range[g] == $past(pd_wdata[4:2], 2))
            else $error("range does not follow config");
        a_span_limit: assert property (
            (run_cmd && $stable(dac_range[g]))[*3] ##0 dac_enable[g]
            |-> in_span(dac_range[g], dac_value[g]))
            else $error("running value outside range span");
    end

    a_power_flag: assert property (
        power_lost_pin[*4] |=> fault_any)
        else $error("supply loss not flagged");
    a_quiet_clear: assert property (
        (!power_lost_pin && open_loop_pin == 4'h0
        && short_out_pin == 4'h0)[*4] |=> !fault_any)
        else $error("fault flag without fault");
    a_power_read: assert property (
        (power_lost_pin && pd_rd_kind == kind_fault)[*5]
        |=> pd_rdata == `FAULT_POWER)
        else $error("supply loss code not read back");
    a_cfg_readback: assert property (
        pd_wr_en && pd_wr_kind == kind_config && pd_rd_kind == kind_config
        && pd_rd_ch == pd_wr_ch ##1 (!pd_wr_en && $stable(pd_rd_kind)
        && $stable(pd_rd_ch)) |=> pd_rdata == $past(pd_wdata, 2))
        else $error("config word not read back");
    a_reset_quiet: assert property (
        $fell(rst) |-> dac_enable == 4'h0 && !fault_any)
        else $error("outputs active after reset");

    c_current_run: cover property (
        run_cmd && dac_enable[1] && dac_range[1] == 3'h4);
    c_fault_seen: cover property ($rose(fault_any));
    c_power_read: cover property (pd_rdata == `FAULT_POWER);
endmodule

bind analog_output_channel_control output_checker output_checker_i (
    .mclk, .rst, .pd_wr_en, .pd_wr_kind, .pd_wr_ch, .pd_wdata, .pd_rd_kind,
    .pd_rd_ch, .run_cmd, .open_loop_pin, .short_out_pin, .power_lost_pin,
    .pd_rdata, .dac_value, .dac_range, .dac_enable, .fault_any);

/* File: dv/analog_output_channel_control_test.sv */
`timescale 1ns/10ps
`include "analog_out_defines.svh"

module analog_output_channel_control_test;
    import analog_out_pkg::*;

    logic mclk, rst, run_cmd, power_lost_pin, pd_wr_en, fault_any;
    logic [3:0] open_loop_pin, short_out_pin, dac_enable;
    word_kind_e pd_wr_kind, pd_rd_kind;
    chan_t pd_wr_ch, pd_rd_ch;
    word_t pd_wdata, pd_rdata;
    word_t dac_value [`NUM_CH];
    logic [2:0] dac_range [`NUM_CH];
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    analog_output_channel_control analog_output_channel_control_i (
        .mclk, .rst, .pd_wr_en, .pd_wr_kind, .pd_wr_ch, .pd_wdata,
        .pd_rd_kind, .pd_rd_ch, .run_cmd, .open_loop_pin, .short_out_pin,
        .power_lost_pin, .pd_rdata, .dac_value, .dac_range, .dac_enable,
        .fault_any);
    coupler_model coupler_model_i (.mclk, .pd_rdata, .pd_wr_en,
        .pd_wr_kind, .pd_wr_ch, .pd_wdata, .pd_rd_kind, .pd_rd_ch);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input word_t got, input word_t exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    function automatic word_t clamp(input logic [2:0] r, input word_t v);
        logic signed [15:0] s, lo, hi;
        s = v;
        case (r)
            3'h0: begin lo = `LIM_ZERO; hi = `LIM_P5000; end
            3'h1: begin lo = `LIM_ZERO; hi = `LIM_P10000; end
            3'h2: begin lo = `LIM_M5000; hi = `LIM_P5000; end
            3'h3: begin lo = `LIM_M10000; hi = `LIM_P10000; end
            3'h4: begin lo = `LIM_P4000; hi = `LIM_P20000; end
            3'h5: begin lo = `LIM_ZERO; hi = `LIM_P20000; end
            default: return 16'h0;
        endcase
        if (s < lo) return lo;
        if (s > hi) return hi;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        word_t w;
        chk({12'h0, dac_enable}, 16'h0, "enable after reset");
        chk(dac_value[0], `OUT_RESET, "value after reset");
        coupler_model_i.get_word(kind_config, 2'h0, w);
        chk(w, `CFG_RESET, "config after reset");
        $display("test_reset done");
    endtask

    task automatic test_ranges;
        word_t w, cfg;
        word_t codes [3] = '{16'h7fff, 16'h8000, 16'h0bb8};
        run_cmd = 1'b1;
        for (int r = 0; r < 8; r++) begin
            cfg = 16'hff83 | 16'(r << 2);
            coupler_model_i.put_word(kind_config, 2'h1, cfg);
            for (int i = 0; i < 3; i++) begin
                coupler_model_i.put_word(kind_code, 2'h1, codes[i]);
                wait_n(3);
                chk(dac_value[1], clamp(3'(r), codes[i]), "scaled");
            end
            chk({13'h0, dac_range[1]}, 16'(r), "range copy");
            chk({15'h0, dac_enable[1]}, {15'h0, r < 6}, "enable");
            coupler_model_i.get_word(kind_config, 2'h1, w);
            chk(w, cfg, "reserved bits kept");
        end
        $display("test_ranges done");
    endtask

    task automatic test_disable;
        coupler_model_i.put_word(kind_config, 2'h2, 16'h000c);
        coupler_model_i.put_word(kind_code, 2'h2, 16'h03e8);
        wait_n(3);
        chk(dac_value[2], 16'h0, "disabled value");
        chk({15'h0, dac_enable[2]}, 16'h0, "disabled flag");
        coupler_model_i.put_word(kind_config, 2'h2, 16'h000d);
        wait_n(3);
        chk(dac_value[2], 16'h03e8, "running code");
        $display("test_disable done");
    endtask

    task automatic test_stop;
        word_t exp [4] = '{16'h0, 16'h07d0, 16'hfc18, 16'h0};
        coupler_model_i.put_word(kind_preset, 2'h3, 16'hfc18);
        for (int p = 0; p < 4; p++) begin
            run_cmd = 1'b1;
            coupler_model_i.put_word(kind_code, 2'h3, 16'h07d0);
            coupler_model_i.put_word(kind_config, 2'h3,
                                     16'h000d | 16'(p << 5));
            wait_n(3);
            chk(dac_value[3], 16'h07d0, "running value");
            run_cmd = 1'b0;
            coupler_model_i.put_word(kind_code, 2'h3, 16'h0001);
            wait_n(3);
            chk(dac_value[3], exp[p], "after stop");
        end
        run_cmd = 1'b1;
        $display("test_stop done");
    endtask

    task automatic test_faults;
        word_t w;
        for (int c = 0; c < 4; c++) begin
            coupler_model_i.put_word(kind_config, 2'(c), 16'h0011);
            open_loop_pin[c] = 1'b1;
            wait_n(6);
            coupler_model_i.get_word(kind_fault, 2'(c), w);
            chk(w, 16'h00b0 + 16'(2 * c), "open loop code");
            chk({15'h0, fault_any}, 16'h1, "fault flag");
            open_loop_pin[c] = 1'b0;
            coupler_model_i.put_word(kind_config, 2'(c), 16'h0005);
            short_out_pin[c] = 1'b1;
            wait_n(6);
            coupler_model_i.get_word(kind_fault, 2'(c), w);
            chk(w, 16'h00b1 + 16'(2 * c), "short code");
            short_out_pin[c] = 1'b0;
            wait_n(6);
            coupler_model_i.put_word(kind_fault, 2'(c), 16'h1234);
            coupler_model_i.get_word(kind_fault, 2'(c), w);
            chk(w, `FAULT_NONE, "fault cleared");
        end
        power_lost_pin = 1'b1;
        wait_n(6);
        for (int c = 0; c < 4; c++) begin
            coupler_model_i.get_word(kind_fault, 2'(c), w);
            chk(w, `FAULT_POWER, "supply loss code");
        end
        power_lost_pin = 1'b0;
        $display("test_faults done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        run_cmd = 1'b0;
        power_lost_pin = 1'b0;
        open_loop_pin = 4'h0;
        short_out_pin = 4'h0;
        wait_n(2);
        rst = 1'b0;
        test_reset();
        test_ranges();
        test_disable();
        test_stop();
        test_faults();
        end_sim();
    end
endmodule

/* File: dv/coupler_model.sv */
`timescale 1ns/10ps

module coupler_model (
    input wire logic mclk,
    input wire analog_out_pkg::word_t pd_rdata,
    output logic pd_wr_en,
    output analog_out_pkg::word_kind_e pd_wr_kind,
    output analog_out_pkg::chan_t pd_wr_ch,
    output analog_out_pkg::word_t pd_wdata,
    output analog_out_pkg::word_kind_e pd_rd_kind,
    output analog_out_pkg::chan_t pd_rd_ch
);
    import analog_out_pkg::*;

    initial begin
        pd_wr_en = 1'b0;
        pd_wr_kind = kind_code;
        pd_wr_ch = 2'h0;
        pd_wdata = 16'h0;
        pd_rd_kind = kind_config;
        pd_rd_ch = 2'h0;
    end

    task automatic put_word(input word_kind_e k, input chan_t c,
                            input word_t d);
        @(negedge mclk);
        pd_wr_en = 1'b1;
        pd_wr_kind = k;
        pd_wr_ch = c;
        pd_wdata = d;
        @(negedge mclk);
        pd_wr_en = 1'b0;
        // Idle data must not look like the last word
        pd_wdata = ~d;
    endtask

    task automatic get_word(input word_kind_e k, input chan_t c,
                            output word_t d);
        @(negedge mclk);
        pd_rd_kind = k;
        pd_rd_ch = c;
        repeat (2) @(negedge mclk);
        d = pd_rdata;
    endtask
endmodule

/* File: pkg/analog_out_defines.svh */
`ifndef ANALOG_OUT_DEFINES_SVH
`define ANALOG_OUT_DEFINES_SVH

// ----------------------------------------------------------------
// Channel count
// ----------------------------------------------------------------
`define NUM_CH 4
`define CH_LAST 2'h3

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define CFG_ENABLE_BIT 0
`define CFG_RSVD_BIT 1
`define CFG_RANGE_MSB 4
`define CFG_RANGE_LSB 2
`define CFG_STOP_MSB 6
`define CFG_STOP_LSB 5
`define CFG_RSVD_MSB 15
`define CFG_RSVD_LSB 7

// ----------------------------------------------------------------
// Range select codes
// ----------------------------------------------------------------
`define RANGE_0_5V 3'h0
`define RANGE_0_10V 3'h1
`define RANGE_PM5V 3'h2
`define RANGE_PM10V 3'h3
`define RANGE_4_20MA 3'h4
`define RANGE_0_20MA 3'h5

// ----------------------------------------------------------------
// After-stop policy codes
// ----------------------------------------------------------------
`define STOP_CLEAR 2'h0
`define STOP_HOLD 2'h1
`define STOP_PRESET 2'h2

// ----------------------------------------------------------------
// Range limits, two's complement
// ----------------------------------------------------------------
`define LIM_ZERO 16'h0000
`define LIM_P5000 16'h1388
`define LIM_M5000 16'hec78
`define LIM_P10000 16'h2710
`define LIM_M10000 16'hd8f0
`define LIM_P4000 16'h0fa0
`define LIM_P20000 16'h4e20

// ----------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------
`define FAULT_NONE 16'h0000
`define FAULT_OPEN_BASE 16'h00b0
`define FAULT_SHORT_BASE 16'h00b1
`define FAULT_POWER 16'h00b8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RESET 16'h0000
`define CODE_RESET 16'h0000
`define PRESET_RESET 16'h0000
`define OUT_RESET 16'h0000

`endif

/* File: pkg/analog_out_pkg.sv */
package analog_out_pkg;

    typedef logic [15:0] word_t;
    typedef logic [1:0] chan_t;
    typedef logic [2:0] range_t;
    typedef logic [1:0] stop_t;

    typedef enum logic [1:0] {
        kind_config,
        kind_code,
        kind_preset,
        kind_fault
    } word_kind_e;

    typedef enum logic {
        run_stopped,
        run_active
    } run_state_e;

endpackage
